// >>> src/serial_bd_pkg.sv
/*
  Shared constants, types and helpers for the descriptor / parameter RAM engine.
  Assumes a single clock domain; all users import the whole package.
*/
package serial_bd_pkg;
  localparam int RAM_BYTES = 2560;
  localparam int RAM_WORDS = RAM_BYTES / 4;
  localparam int AW        = 10;
  localparam int CTRL_W    = 10;
  localparam int NEV       = 5;

  // Parameter region starts at byte 0x800; each channel owns sixteen words
  localparam logic [AW-1:0] PAR_BASE_W = 10'h200;
  localparam logic [3:0]    PW_BASES   = 4'h0;
  localparam logic [3:0]    PW_PTRS    = 4'h1;
  localparam logic [3:0]    PW_LENFC   = 4'h2;
  localparam logic [3:0]    PW_PROTO   = 4'h4;

  localparam logic [15:0] DESC_STRIDE = 16'h0008;
  localparam logic [15:0] DESC_W1_OFS = 16'h0004;
  localparam int          SC_READY    = 15;
  localparam int          SC_WRAP     = 13;
  localparam int          SC_XBIT     = 11;
  localparam int          CRC_EN_BIT  = 0;

  localparam logic [11:0] RAM_TOP   = 12'ha00;
  localparam logic [11:0] REG_CTRL  = 12'ha00;
  localparam logic [11:0] REG_STAT  = 12'ha04;
  localparam logic [11:0] REG_MASK  = 12'ha08;
  localparam logic [11:0] REG_MBASE = 12'ha0c;

  localparam int CTRL_EN       = 0;
  localparam int CTRL_WIDE     = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 10'h000;
  localparam logic [NEV-1:0]    MASK_RST  = 5'h00;
  localparam logic [31:0]       MBASE_RST = 32'h0000_0000;

  localparam int EV_DONE  = 0;
  localparam int EV_BUSY  = 1;
  localparam int EV_IDLE  = 2;
  localparam int EV_FRAME = 3;
  localparam int EV_ALIGN = 4;

  typedef enum logic [1:0] {
    MODE_GEN = 2'h0, MODE_UART = 2'h1, MODE_HDLC = 2'h2, MODE_TRANSP = 2'h3
  } mode_e;

  typedef enum logic [1:0] {
    OP_BUF = 2'h0, OP_IDLE = 2'h1, OP_FRAME = 2'h2, OP_NONE = 2'h3
  } op_e;

  typedef struct packed {
    logic [1:0]  chan;
    logic        rx;
    op_e         op;
    logic [15:0] len;
  } req_s;

  typedef struct packed {
    logic [1:0]  chan;
    logic        ok;
    logic        crc_en;
    logic [31:0] addr;
    logic [31:0] desc_addr;
    logic [7:0]  fc;
    logic [15:0] len;
    logic [15:0] sc;
  } resp_s;

  function automatic logic [AW-1:0] par_addr(input logic [1:0] ch, input logic [3:0] w);
    par_addr = PAR_BASE_W + {4'h0, ch, w};
  endfunction

  // Offset bits above bit 11 are dropped, so wider offsets wrap within the 4096-byte window
  function automatic logic [AW-1:0] off2w(input logic [15:0] off);
    off2w = off[AW+1:2];
  endfunction
endpackage

// >>> src/bd_dpram.sv
/*
  Dual-port word RAM holding user data, descriptors and channel parameters.
  Assumes both ports are in the clk domain; read data is registered.
*/
`timescale 1ns/10ps
module bd_dpram
  import serial_bd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          a_en,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [31:0]   a_wdata,
  output logic      [31:0]   a_rdata,
  input  wire logic          b_we,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [31:0]   b_wdata,
  output logic      [31:0]   b_rdata
);
  logic [31:0] mem [RAM_WORDS];

  // No reset on the array; out-of-range words read as zero and drop writes
  always_ff @(posedge clk) begin
    if (ce) begin
      if (a_en && a_we && a_addr < AW'(RAM_WORDS)) begin
        mem[a_addr] <= a_wdata;
      end
      if (b_we && b_addr < AW'(RAM_WORDS)) begin
        mem[b_addr] <= b_wdata;
      end
      a_rdata <= (a_addr < AW'(RAM_WORDS)) ? mem[a_addr] : 32'h0000_0000;
      b_rdata <= (b_addr < AW'(RAM_WORDS)) ? mem[b_addr] : 32'h0000_0000;
    end
  end
endmodule

// >>> src/serial_bd_param_ram.sv
/*
  Descriptor walker and parameter RAM for four serial channels, with APB access.
  Assumes the serial channels hold a request until accepted and that software
  programs the parameter areas before enabling a channel.
*/
// What this block does
// - Descriptor is a 16-bit status/control, a 16-bit length, then a buffer pointer
// - All 32 bits of the buffer pointer are handed out as the system address
// - Current descriptor offsets are 16-bit RAM offsets; address is module base plus offset
// - Descriptor tables may sit anywhere in the user region of the RAM
// - The dual-port RAM holds 2560 bytes, user region plus parameter region
// - In UART mode an idle-character limit of zero disables the idle timeout
// - Four channel areas, each a common part plus a protocol-specific part
// - In HDLC mode a threshold and counter give one interrupt per frame group
// - Transparent CRC option is taken from its parameter area, initialised first
// - The former internal/external address bit of the status word is ignored
`timescale 1ns/10ps
module serial_bd_param_ram
  import serial_bd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  input  wire req_s        req,
  output logic             req_ready,
  output logic             resp_valid,
  output resp_s            resp,
  output logic             irq
);
  typedef enum logic [2:0] {
    A_IDLE = 3'b001, A_FETCH = 3'b010, A_DONE = 3'b100
  } apb_e;

  typedef enum logic [10:0] {
    S_IDLE  = 11'h001, S_RPTR  = 11'h002, S_RX_TABLE_BASE = 11'h004, S_RFC  = 11'h008,
    S_RD0   = 11'h010, S_RD1   = 11'h020, S_RPROT = 11'h040, S_WDESC = 11'h080,
    S_WPTR  = 11'h100, S_WPAR  = 11'h200, S_DONE  = 11'h400
  } state_e;

  function automatic mode_e chan_mode(input logic [CTRL_W-1:0] c, input logic [1:0] ch);
    chan_mode = mode_e'(c[CTRL_MODE_LSB + 2 * ch +: 2]);
  endfunction

  apb_e              ph_reg, ph_next;
  logic [31:0]       prdata_reg, prdata_next;
  logic              pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [NEV-1:0]    stat_reg, stat_next, mask_reg, mask_next;
  logic [31:0]       mbase_reg, mbase_next;
  logic              irq_reg, irq_next;
  logic              a_en, a_we;
  logic [31:0]       a_rdata, b_rdata, b_wdata;
  logic [AW-1:0]     b_addr;
  logic              b_we;
  logic              hit_ram, hit_reg;
  logic [31:0]       reg_rd;

  state_e            st_reg, st_next;
  req_s              rq_reg, rq_next;
  logic [31:0]       ptrs_reg, ptrs_next, bases_reg, bases_next;
  logic [31:0]       lenfc_reg, lenfc_next, d0_reg, d0_next, d1_reg, d1_next;
  resp_s             resp_reg, resp_next;
  logic              done_reg, done_next, rdy_reg, rdy_next;
  logic [NEV-1:0]    ev;
  logic [15:0]       cur, base, new_off, sc_new, lim, cnt;
  mode_e             mode;

  bd_dpram u_ram (
    .clk     (clk),
    .ce      (ce),
    .a_en    (a_en),
    .a_we    (a_we),
    .a_addr  (paddr[11:2]),
    .a_wdata (pwdata),
    .a_rdata (a_rdata),
    .b_we    (b_we),
    .b_addr  (b_addr),
    .b_wdata (b_wdata),
    .b_rdata (b_rdata)
  );

  // APB slave: fixed two wait states so RAM read data can be registered
  always_comb begin
    ph_next      = ph_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = pslverr_reg;
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    mbase_next   = mbase_reg;
    stat_next    = stat_reg;
    a_en         = 1'b0;
    a_we         = 1'b0;
    hit_ram      = paddr < RAM_TOP;
    hit_reg      = paddr == REG_CTRL || paddr == REG_STAT ||
                   paddr == REG_MASK || paddr == REG_MBASE;
    reg_rd       = 32'h0000_0000;
    unique case (paddr)
      REG_CTRL:  reg_rd[CTRL_W-1:0] = ctrl_reg;
      REG_STAT:  reg_rd[NEV-1:0]    = stat_reg;
      REG_MASK:  reg_rd[NEV-1:0]    = mask_reg;
      REG_MBASE: reg_rd             = mbase_reg;
      default:   reg_rd             = 32'h0000_0000;
    endcase
    unique case (ph_reg)
      A_IDLE: if (psel && penable) begin
        a_en    = hit_ram;
        ph_next = A_FETCH;
      end
      A_FETCH: begin
        prdata_next  = hit_ram ? a_rdata : reg_rd;
        pslverr_next = !(hit_ram || hit_reg);
        pready_next  = 1'b1;
        ph_next      = A_DONE;
      end
      A_DONE: begin
        ph_next = A_IDLE;
        if (pwrite && !pslverr_reg) begin
          a_en = hit_ram;
          a_we = hit_ram;
          unique case (paddr)
            REG_CTRL:  ctrl_next  = pwdata[CTRL_W-1:0];
            REG_STAT:  stat_next  = stat_reg & ~pwdata[NEV-1:0];
            REG_MASK:  mask_next  = pwdata[NEV-1:0];
            REG_MBASE: mbase_next = pwdata;
            default:   ctrl_next  = ctrl_reg;
          endcase
        end
      end
      default: ph_next = A_IDLE;
    endcase
    // Hardware events win over a software clear in the same cycle
    stat_next = stat_next | ev;
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ph_reg      <= A_IDLE;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      ctrl_reg    <= CTRL_RST;
      stat_reg    <= 5'h00;
      mask_reg    <= MASK_RST;
      mbase_reg   <= MBASE_RST;
      irq_reg     <= 1'b0;
    end else if (ce) begin
      ph_reg      <= ph_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      ctrl_reg    <= ctrl_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      mbase_reg   <= mbase_next;
      irq_reg     <= irq_next;
    end
  end

  // Descriptor engine on the second RAM port
  always_comb begin
    st_next    = st_reg;
    rq_next    = rq_reg;
    ptrs_next  = ptrs_reg;
    bases_next = bases_reg;
    lenfc_next = lenfc_reg;
    d0_next    = d0_reg;
    d1_next    = d1_reg;
    resp_next  = resp_reg;
    done_next  = 1'b0;
    ev         = 5'h00;
    b_addr     = 10'h000;
    b_we       = 1'b0;
    b_wdata    = 32'h0000_0000;
    cur        = rq_reg.rx ? ptrs_reg[31:16] : ptrs_reg[15:0];
    base       = rq_reg.rx ? bases_reg[31:16] : bases_reg[15:0];
    new_off    = d0_reg[16+SC_WRAP] ? base : 16'(cur + DESC_STRIDE);
    sc_new     = d0_reg[31:16];
    sc_new[SC_READY] = 1'b0;
    mode       = chan_mode(ctrl_reg, rq_reg.chan);
    lim        = b_rdata[31:16];
    cnt        = b_rdata[15:0];
    unique case (st_reg)
      S_IDLE: if (req_valid && rdy_reg) begin
        rq_next = req;
        st_next = (req.op == OP_BUF) ? S_RPTR : S_RPROT;
      end
      S_RPTR: begin
        b_addr  = par_addr(rq_reg.chan, PW_PTRS);
        st_next = S_RX_TABLE_BASE;
      end
      S_RX_TABLE_BASE: begin
        ptrs_next = b_rdata;
        b_addr    = par_addr(rq_reg.chan, PW_BASES);
        st_next   = S_RFC;
      end
      S_RFC: begin
        bases_next = b_rdata;
        b_addr     = par_addr(rq_reg.chan, PW_LENFC);
        st_next    = S_RD0;
      end
      S_RD0: begin
        lenfc_next = b_rdata;
        b_addr     = off2w(cur);
        st_next    = S_RD1;
      end
      S_RD1: begin
        d0_next = b_rdata;
        b_addr  = off2w(16'(cur + DESC_W1_OFS));
        st_next = S_RPROT;
      end
      S_RPROT: begin
        if (rq_reg.op == OP_BUF) begin
          d1_next = b_rdata;
        end
        b_addr  = par_addr(rq_reg.chan, PW_PROTO);
        st_next = (rq_reg.op == OP_BUF) ? S_WDESC : S_WPAR;
      end
      S_WDESC: begin
        resp_next.chan      = rq_reg.chan;
        resp_next.ok        = d0_reg[16+SC_READY];
        resp_next.crc_en    = mode == MODE_TRANSP && b_rdata[CRC_EN_BIT];
        resp_next.addr      = d1_reg;
        resp_next.desc_addr = mbase_reg + {16'h0000, cur};
        resp_next.fc        = rq_reg.rx ? lenfc_reg[15:8] : lenfc_reg[7:0];
        resp_next.len       = rq_reg.rx ? rq_reg.len : d0_reg[15:0];
        resp_next.sc        = sc_new;
        resp_next.sc[SC_XBIT] = 1'b0;
        b_addr  = off2w(cur);
        b_we    = d0_reg[16+SC_READY];
        b_wdata = {sc_new, resp_next.len};
        // Misalignment is software's fault; flag it rather than fix it
        ev[EV_ALIGN] = rq_reg.rx && ctrl_reg[CTRL_WIDE] &&
                       (d1_reg[1:0] != 2'h0 || lenfc_reg[17:16] != 2'h0);
        st_next = S_WPTR;
      end
      S_WPTR: begin
        b_addr  = par_addr(rq_reg.chan, PW_PTRS);
        b_we    = resp_reg.ok;
        b_wdata = rq_reg.rx ? {new_off, ptrs_reg[15:0]} : {ptrs_reg[31:16], new_off};
        ev[EV_DONE] = resp_reg.ok;
        ev[EV_BUSY] = !resp_reg.ok;
        st_next = S_DONE;
      end
      S_WPAR: begin
        resp_next        = '0;
        resp_next.chan   = rq_reg.chan;
        resp_next.crc_en = mode == MODE_TRANSP && b_rdata[CRC_EN_BIT];
        b_addr           = par_addr(rq_reg.chan, PW_PROTO);
        if (mode == MODE_UART && rq_reg.op == OP_IDLE && lim != 16'h0000) begin
          b_we         = 1'b1;
          ev[EV_IDLE]  = 16'(cnt + 16'h0001) >= lim;
          b_wdata      = ev[EV_IDLE] ? {lim, 16'h0000} : {lim, 16'(cnt + 16'h0001)};
        end
        if (mode == MODE_HDLC && rq_reg.op == OP_FRAME) begin
          b_we         = 1'b1;
          ev[EV_FRAME] = cnt <= 16'h0001;
          b_wdata      = ev[EV_FRAME] ? {lim, lim} : {lim, 16'(cnt - 16'h0001)};
        end
        st_next = S_DONE;
      end
      S_DONE: begin
        done_next = 1'b1;
        st_next   = S_IDLE;
      end
    endcase
    rdy_next = st_next == S_IDLE && ctrl_reg[CTRL_EN];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg    <= S_IDLE;
      rq_reg    <= '0;
      ptrs_reg  <= 32'h0000_0000;
      bases_reg <= 32'h0000_0000;
      lenfc_reg <= 32'h0000_0000;
      d0_reg    <= 32'h0000_0000;
      d1_reg    <= 32'h0000_0000;
      resp_reg  <= '0;
      done_reg  <= 1'b0;
      rdy_reg   <= 1'b0;
    end else if (ce) begin
      st_reg    <= st_next;
      rq_reg    <= rq_next;
      ptrs_reg  <= ptrs_next;
      bases_reg <= bases_next;
      lenfc_reg <= lenfc_next;
      d0_reg    <= d0_next;
      d1_reg    <= d1_next;
      resp_reg  <= resp_next;
      done_reg  <= done_next;
      rdy_reg   <= rdy_next;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign req_ready  = rdy_reg;
  assign resp_valid = done_reg;
  assign resp       = resp_reg;
  assign irq        = irq_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_PTR_FULL: assert property (
    done_reg && rq_reg.op == OP_BUF |-> resp_reg.addr == d1_reg)
    else $error("buffer pointer not passed through whole");
  AST_DESC_ADDR: assert property (
    done_reg && rq_reg.op == OP_BUF |-> resp_reg.desc_addr == mbase_reg + {16'h0000, cur})
    else $error("descriptor address is not base plus offset");
  AST_DESC_ANY: assert property (
    st_reg == S_RD0 && ce |=> st_reg == S_RD1 && $past(b_addr) == off2w(cur))
    else $error("descriptor not fetched at current offset");
  AST_RAM_WIN: assert property (
    ph_reg == A_FETCH && paddr < RAM_TOP |=> pready_reg && !pslverr_reg)
    else $error("RAM word inside 2560 bytes refused");
  AST_IDLE_OFF: assert property (
    st_reg == S_WPAR && mode == MODE_UART && rq_reg.op == OP_IDLE && lim == 16'h0000
    |-> !b_we && !ev[EV_IDLE])
    else $error("zero idle limit still active");
  AST_FRAME_GROUP: assert property (
    st_reg == S_WPAR && mode == MODE_HDLC && rq_reg.op == OP_FRAME && cnt > 16'h0001
    |-> !ev[EV_FRAME] && b_wdata[15:0] == cnt - 16'h0001)
    else $error("frame event before threshold reached");
  AST_CRC_MODE: assert property (
    done_reg && chan_mode(ctrl_reg, rq_reg.chan) != MODE_TRANSP |-> !resp_reg.crc_en)
    else $error("CRC option outside transparent mode");
  AST_X_IGNORED: assert property (
    done_reg |-> !resp_reg.sc[SC_XBIT])
    else $error("address-space bit leaked");
  AST_WRAP: assert property (
    st_reg == S_WPTR && b_we && d0_reg[16+SC_WRAP] |->
    (rq_reg.rx ? b_wdata[31:16] : b_wdata[15:0]) == base)
    else $error("table end did not wrap to base");
  AST_IRQ: assert property (
    ##1 irq_reg == |(stat_reg & mask_reg))
    else $error("interrupt does not follow status and mask");

  COV_BUF_OK:  cover property (done_reg && resp_reg.ok && rq_reg.op == OP_BUF);
  COV_IDLE:    cover property (ev[EV_IDLE]);
  COV_FRAME:   cover property (ev[EV_FRAME]);
  COV_WRAPPED: cover property (st_reg == S_WPTR && b_we && d0_reg[16+SC_WRAP]);
endmodule

// >>> verif/serial_chan_model.sv
/*
  Behavioural model of the serial channels that ask the descriptor engine for work.
  Assumes one clock; the bench calls issue() and reads last afterwards.
*/
`timescale 1ns/10ps
module serial_chan_model
  import serial_bd_pkg::*;
(
  input  wire logic  clk,
  output logic       req_valid,
  output req_s       req,
  input  wire logic  req_ready,
  input  wire logic  resp_valid,
  input  wire resp_s resp
);
  resp_s last;
  logic  timed_out;

  initial begin
    req_valid = 1'b0;
    req = '0;
    last = '0;
    timed_out = 1'b0;
  end

  // Request held until taken; released bus shows the inverse so stale data never looks valid
  task automatic issue(input logic [1:0] ch, input logic rx, input op_e op,
                       input logic [15:0] len, input int gap);
    int n;
    n = 0;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{chan: ch, rx: rx, op: op, len: len};
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    req_valid <= 1'b0;
    req <= req_s'(~{ch, rx, op, len});
    timed_out = timed_out | (n >= 100);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 100);
    last = resp;
    timed_out = timed_out | (n >= 100);
  endtask
endmodule

// >>> verif/serial_bd_param_ram_bench.sv
/*
  Self-checking bench: APB register and RAM access, descriptor walks and events.
  Assumes the channel model drives the request port; clock enable stays high.
*/
`timescale 1ns/10ps
module serial_bd_param_ram_bench
  import serial_bd_pkg::*;
;
  logic        clk;
  logic        resetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        req_valid;
  req_s        req;
  logic        req_ready;
  logic        resp_valid;
  resp_s       resp;
  logic        irq;
  logic [31:0] rv;
  logic        er;
  int          bad_count;
  int          compares;
  int          cycles;
  bit          apb_hung;

  serial_bd_param_ram u_dut (
    .clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .irq(irq)
  );

  serial_chan_model u_chan (
    .clk(clk), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp(resp)
  );

  always #2.5 clk = ~clk;

  function automatic logic [31:0] z(input logic v);
    return {31'h0, v};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) apb_hung = 1'b1;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rv, er);
    chk(rv, exp);
  endtask

  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000 || apb_hung || u_chan.timed_out === 1'b1) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(REG_CTRL, {22'h0, CTRL_RST});
    rd(REG_STAT, 32'h0);
    rd(REG_MASK, {27'h0, MASK_RST});
    rd(REG_MBASE, MBASE_RST);
    apb(1'b1, 12'ha10, 32'hffff_ffff, rv, er);
    chk(z(er), 32'h1);
    apb(1'b0, 12'ha10, 32'h0, rv, er);
    chk(z(er), 32'h1);
    chk(rv, 32'h0);
    wr(12'h9fc, 32'hcafe_f00d);
    rd(12'h9fc, 32'hcafe_f00d);
    for (int c = 0; c < 4; c++) wr(12'h810 + 12'(c * 64), 32'h5a00 + c);
    for (int c = 0; c < 4; c++) rd(12'h810 + 12'(c * 64), 32'h5a00 + c);
    // Channel 0 tables in user RAM, long-word aligned bases and pointers
    wr(REG_MBASE, 32'h4000_0000);
    wr(12'h800, 32'h0100_0200);
    wr(12'h804, 32'h0108_0200);
    wr(12'h808, 32'h0040_1818);
    wr(12'h810, 32'h0003_0003);
    wr(12'h108, 32'ha800_0000);
    wr(12'h10c, 32'h1234_5678);
    wr(12'h100, 32'h8000_0000);
    wr(12'h104, 32'h0000_2000);
    wr(12'h200, 32'ha000_0020);
    wr(12'h204, 32'h0000_3000);
    wr(12'h850, 32'h0);
    wr(12'h890, 32'h1);
    wr(REG_MASK, 32'h1);
    wr(REG_CTRL, 32'h0000_00db);
    chk(z(irq), 32'h0);
    // Wrapping descriptor with the old address-space bit set
    u_chan.issue(2'd0, 1'b1, OP_BUF, 16'h0010, 0);
    chk(z(u_chan.last.ok), 32'h1);
    chk(u_chan.last.addr, 32'h1234_5678);
    chk(u_chan.last.desc_addr, 32'h4000_0108);
    chk({24'h0, u_chan.last.fc}, 32'h18);
    chk(z(u_chan.last.sc[SC_XBIT]), 32'h0);
    rd(12'h108, 32'h2800_0010);
    rd(12'h804, 32'h0100_0200);
    rd(REG_STAT, 32'h1);
    chk(z(irq), 32'h1);
    wr(REG_STAT, 32'h1);
    rd(REG_STAT, 32'h0);
    chk(z(irq), 32'h0);
    // Plain step to the next descriptor, requested slowly
    u_chan.issue(2'd0, 1'b1, OP_BUF, 16'h0004, 3);
    chk(u_chan.last.addr, 32'h0000_2000);
    chk(u_chan.last.desc_addr, 32'h4000_0100);
    rd(12'h100, 32'h0000_0004);
    rd(12'h804, 32'h0108_0200);
    // Descriptor already closed: refused, nothing written back
    u_chan.issue(2'd0, 1'b1, OP_BUF, 16'h0008, 0);
    chk(z(u_chan.last.ok), 32'h0);
    rd(12'h804, 32'h0108_0200);
    rd(12'h108, 32'h2800_0010);
    rd(REG_STAT, 32'h3);
    chk(z(irq), 32'h1);
    wr(REG_MASK, 32'h0);
    // The mask write lands at the pready edge; irq shows it on that same edge
    @(posedge clk);
    chk(z(irq), 32'h0);
    // Transmit side keeps the descriptor's own length and wraps in place
    u_chan.issue(2'd0, 1'b0, OP_BUF, 16'hffff, 0);
    chk(z(u_chan.last.ok), 32'h1);
    chk(u_chan.last.addr, 32'h0000_3000);
    chk(u_chan.last.desc_addr, 32'h4000_0200);
    chk({16'h0, u_chan.last.len}, 32'h20);
    rd(12'h200, 32'h2000_0020);
    rd(12'h804, 32'h0108_0200);
    wr(REG_STAT, 32'h3);
    rd(REG_STAT, 32'h0);
    // Frame grouping on channel 0
    u_chan.issue(2'd0, 1'b1, OP_FRAME, 16'h0, 0);
    rd(REG_STAT, 32'h0);
    u_chan.issue(2'd0, 1'b1, OP_FRAME, 16'h0, 0);
    u_chan.issue(2'd0, 1'b1, OP_FRAME, 16'h0, 0);
    rd(REG_STAT, 32'h8);
    // Idle limit of zero never fires; limit of two fires on the second
    u_chan.issue(2'd1, 1'b1, OP_IDLE, 16'h0, 0);
    u_chan.issue(2'd1, 1'b1, OP_IDLE, 16'h0, 0);
    rd(REG_STAT, 32'h8);
    rd(12'h850, 32'h0);
    wr(12'h850, 32'h0002_0000);
    u_chan.issue(2'd1, 1'b1, OP_IDLE, 16'h0, 0);
    rd(REG_STAT, 32'h8);
    u_chan.issue(2'd1, 1'b1, OP_IDLE, 16'h0, 0);
    rd(REG_STAT, 32'hc);
    u_chan.issue(2'd2, 1'b0, OP_FRAME, 16'h0, 0);
    chk(z(u_chan.last.crc_en), 32'h1);
    end_sim();
  end
endmodule
